// *** ubir_pkg.sv ***
// Shared constants for the baud divisor, debug control and infrared coder block.
// Assumes an 8-bit register port with byte offsets as listed below.
`default_nettype none
package ubir_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int DIV_W = 16;
  localparam int RX_FILTER_SAMPLE_COUNT_W = 7;
  localparam logic [7:0] OFS_DIV_LOW = 8'h08;
  localparam logic [7:0] OFS_DIV_HIGH = 8'h09;
  localparam logic [7:0] OFS_DBG = 8'h0b;
  localparam logic [7:0] OFS_INFRARED_EVENT_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_TX_PULSE_WIDTH_VALUE = 8'h0d;
  localparam logic [7:0] OFS_RX_FILTER_SAMPLE_COUNT = 8'h0e;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BIT_RUN_DBG = 0;
  localparam int BIT_EV_IN = 0;
  localparam logic [7:0] TX_PULSE_WIDTH_VALUE_SIXTEENTHS = 8'h00;
  localparam logic [7:0] TX_PULSE_WIDTH_VALUE_BYPASS = 8'hff;
  localparam logic [1:0] CMODE_INFRARED_COMM_MODE = 2'h2;
  localparam logic [7:0] PULSE_SIXTEENTHS = 8'h03;
  localparam logic [3:0] SAMPLE_LAST = 4'hf;
  localparam logic [4:0] BIT_SAMPLES = 5'h10;
endpackage
`default_nettype wire

// *** ubir_sync.sv ***
// Three-stage synchroniser for one pin input.
// The output moves only once the second and third stages agree.
`default_nettype none
module ubir_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin_in,
  output logic sync_out
);
  logic s1_reg, s2_reg, s3_reg, out_reg;
  logic out_next;

  always_comb begin
    out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      out_reg <= RESET_VAL;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;
endmodule
`default_nettype wire

// *** ubir_rx_filter.sv ***
// Infrared receive pulse filter: a new level is taken after len+1 equal samples.
// Disabled, it passes the input through one register.
`default_nettype none
module ubir_rx_filter #(
  parameter int LEN_W = 7
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic en,
  input wire logic ce,
  input wire logic [LEN_W-1:0] len,
  input wire logic din,
  output logic dout
);
  logic out_reg, out_next;
  logic [LEN_W-1:0] cnt_reg, cnt_next;

  always_comb begin
    out_next = out_reg;
    cnt_next = cnt_reg;
    if (!en) begin
      out_next = din; // [RULE_14]
      cnt_next = '0;
    end else if (ce) begin
      if (din == out_reg) begin
        cnt_next = '0;
      end else if (cnt_reg == len) begin
        out_next = din; // [RULE_15]
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_reg <= 1'b1;
      cnt_reg <= '0;
    end else begin
      out_reg <= out_next;
      cnt_reg <= cnt_next;
    end
  end

  assign dout = out_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_filter_off: assert property (!en |=> dout == $past(din)) // [RULE_14]
    else $error("Disabled filter did not pass input");
  a_filter_count: assert property ( // [RULE_15]
    $past(en) && $changed(dout) |-> $past(cnt_reg) == $past(len) && $past(ce))
    else $error("Filter accepted a pulse before len+1 samples");
endmodule
`default_nettype wire

// *** ubir_top.sv ***
// Baud divisor, debug-run control and infrared pulse coder/decoder of a USART.
// Expects an 8-bit register port, a same-clock transmitter and receiver,
// and an asynchronous receive pin.
// Functional notes
// [RULE_01] Divisor is two bytes at base, base+1
// [RULE_02] Divisor write reloads prescaler at once
// [RULE_03] Software changes divisor only when idle
// [RULE_04] Debug halt without run bit freezes block
// [RULE_05] Run bit set keeps block running halted
// [RULE_06] Event enable selects event as IR input
// [RULE_07] Event input disconnects the receive pin
// [RULE_08] Pulse width zero gives 3/16 bit pulses
// [RULE_09] Width 1..254 gives that many clocks
// [RULE_10] Pulses start on baud clock rising edge
// [RULE_11] Width 255 bypasses coding both directions
// [RULE_12] Transmit width matters only in IR mode
// [RULE_13] Software sets transmit width before enabling
// [RULE_14] Receive length zero disables the filter
// [RULE_15] Length x accepts after x+1 equal samples
// [RULE_16] Receive length matters only in IR mode
// [RULE_17] Software sets receive length before enabling
// [RULE_18] Software keeps speed mode normal in IR
`default_nettype none
module ubir_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ubir_pkg::ADDR_W-1:0] addr,
  input wire logic [ubir_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [ubir_pkg::DATA_W-1:0] rd_data,
  input wire logic [1:0] comm_mode,
  input wire logic transmitter_enable,
  input wire logic receiver_enable,
  input wire logic debug_halted,
  input wire logic event_in,
  input wire logic rxd_pin,
  input wire logic tx_serial,
  output logic txd_out,
  output logic rx_serial,
  output logic sample_tick,
  output logic [ubir_pkg::DIV_W-1:0] baud_divisor
);
  logic [15:0] div_reg, div_next;
  logic [7:0] dbg_reg, dbg_next;
  logic [7:0] ev_reg, ev_next;
  logic [7:0] tx_pulse_width_value_reg, tx_pulse_width_value_next;
  logic [6:0] rx_filter_sample_count_reg, rx_filter_sample_count_next;
  logic [7:0] rd_reg, rd_next;
  logic [15:0] presc_reg, presc_next;
  logic tick_reg, tick_next;
  logic [3:0] samp_reg, samp_next;
  logic [7:0] pulse_reg, pulse_next;
  logic frac_reg, frac_next;
  logic txd_reg, txd_next;
  logic [4:0] demod_reg, demod_next;
  logic prev_reg, prev_next;
  logic rx_reg, rx_next;
  logic halted, ir_mode, bypass, coded, div_wr, baud_rise, pulse_start;
  logic ev_gated, rx_src, rxd_sync, rx_filt, filt_en;

  ubir_sync #(.RESET_VAL(1'b1)) u_rxd_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(rxd_pin),
    .sync_out(rxd_sync)
  );

  // Register file
  always_comb begin
    div_next = div_reg;
    dbg_next = dbg_reg;
    ev_next = ev_reg;
    tx_pulse_width_value_next = tx_pulse_width_value_reg;
    rx_filter_sample_count_next = rx_filter_sample_count_reg;
    rd_next = '0;
    if (wr_en) begin
      unique case (addr)
        ubir_pkg::OFS_DIV_LOW: div_next[7:0] = wr_data; // [RULE_01]
        ubir_pkg::OFS_DIV_HIGH: div_next[15:8] = wr_data; // [RULE_01]
        ubir_pkg::OFS_DBG: dbg_next = {7'h00, wr_data[ubir_pkg::BIT_RUN_DBG]};
        ubir_pkg::OFS_INFRARED_EVENT_CONTROL: ev_next = {7'h00, wr_data[ubir_pkg::BIT_EV_IN]};
        ubir_pkg::OFS_TX_PULSE_WIDTH_VALUE: tx_pulse_width_value_next = wr_data;
        ubir_pkg::OFS_RX_FILTER_SAMPLE_COUNT: rx_filter_sample_count_next = wr_data[6:0];
        default: ;
      endcase
    end
    if (rd_en) begin
      unique case (addr)
        ubir_pkg::OFS_DIV_LOW: rd_next = div_reg[7:0];
        ubir_pkg::OFS_DIV_HIGH: rd_next = div_reg[15:8];
        ubir_pkg::OFS_DBG: rd_next = dbg_reg;
        ubir_pkg::OFS_INFRARED_EVENT_CONTROL: rd_next = ev_reg;
        ubir_pkg::OFS_TX_PULSE_WIDTH_VALUE: rd_next = tx_pulse_width_value_reg;
        ubir_pkg::OFS_RX_FILTER_SAMPLE_COUNT: rd_next = {1'b0, rx_filter_sample_count_reg};
        default: rd_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_reg <= ubir_pkg::DIV_RESET;
      dbg_reg <= ubir_pkg::CTRL_RESET;
      ev_reg <= ubir_pkg::CTRL_RESET;
      tx_pulse_width_value_reg <= ubir_pkg::CTRL_RESET;
      rx_filter_sample_count_reg <= ubir_pkg::CTRL_RESET[6:0];
      rd_reg <= '0;
    end else begin
      div_reg <= div_next;
      dbg_reg <= dbg_next;
      ev_reg <= ev_next;
      tx_pulse_width_value_reg <= tx_pulse_width_value_next;
      rx_filter_sample_count_reg <= rx_filter_sample_count_next;
      rd_reg <= rd_next;
    end
  end

  // Mode decode
  always_comb begin
    halted = debug_halted && !dbg_reg[ubir_pkg::BIT_RUN_DBG]; // [RULE_04] [RULE_05]
    ir_mode = comm_mode == ubir_pkg::CMODE_INFRARED_COMM_MODE; // [RULE_12] [RULE_16]
    bypass = tx_pulse_width_value_reg == ubir_pkg::TX_PULSE_WIDTH_VALUE_BYPASS; // [RULE_11]
    coded = ir_mode && !bypass;
    div_wr = wr_en && (addr == ubir_pkg::OFS_DIV_LOW || addr == ubir_pkg::OFS_DIV_HIGH);
    ev_gated = halted ? 1'b1 : event_in; // [RULE_04]
    // Pin is not looked at while the event channel feeds the receiver
    rx_src = (ir_mode && ev_reg[ubir_pkg::BIT_EV_IN]) ? ev_gated : rxd_sync; // [RULE_06] [RULE_07]
    filt_en = coded && rx_filter_sample_count_reg != '0; // [RULE_14] [RULE_16]
  end

  ubir_rx_filter #(.LEN_W(ubir_pkg::RX_FILTER_SAMPLE_COUNT_W)) u_rx_filter (
    .clk_sys(clk_sys),
    .reset(reset),
    .en(filt_en),
    .ce(!halted),
    .len(rx_filter_sample_count_reg),
    .din(rx_src),
    .dout(rx_filt)
  );

  // Prescaler and sixteenth-bit sample counter
  always_comb begin
    presc_next = presc_reg;
    tick_next = 1'b0;
    samp_next = samp_reg;
    // A divisor write restarts the count so the new rate applies at once
    if (div_wr) begin
      presc_next = div_next; // [RULE_02]
    end else if (!halted) begin
      if (presc_reg == '0) begin
        presc_next = div_reg;
        tick_next = 1'b1;
        samp_next = samp_reg + 1'b1;
      end else begin
        presc_next = presc_reg - 1'b1;
      end
    end
    baud_rise = tick_next && samp_reg == ubir_pkg::SAMPLE_LAST;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      presc_reg <= ubir_pkg::DIV_RESET;
      tick_reg <= 1'b0;
      samp_reg <= '0;
    end else begin
      presc_reg <= presc_next;
      tick_reg <= tick_next;
      samp_reg <= samp_next;
    end
  end

  // Transmit modulator: a zero bit becomes one short low pulse
  always_comb begin
    pulse_next = pulse_reg;
    frac_next = frac_reg;
    pulse_start = coded && transmitter_enable && baud_rise && !tx_serial
      && pulse_reg == '0; // [RULE_10]
    if (pulse_start) begin
      frac_next = tx_pulse_width_value_reg == ubir_pkg::TX_PULSE_WIDTH_VALUE_SIXTEENTHS;
      pulse_next = frac_next ? ubir_pkg::PULSE_SIXTEENTHS : tx_pulse_width_value_reg; // [RULE_08] [RULE_09]
    end else if (!halted && pulse_reg != '0 && (!frac_reg || tick_next)) begin
      pulse_next = pulse_reg - 1'b1;
    end
    txd_next = coded ? pulse_next == '0 : tx_serial; // [RULE_11] [RULE_12]
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pulse_reg <= '0;
      frac_reg <= 1'b0;
      txd_reg <= 1'b1;
    end else begin
      pulse_reg <= pulse_next;
      frac_reg <= frac_next;
      txd_reg <= txd_next;
    end
  end

  // Receive demodulator: a falling pulse edge stretches to one bit time
  always_comb begin
    demod_next = demod_reg;
    prev_next = rx_filt;
    if (!coded) begin
      demod_next = '0;
    end else if (prev_reg && !rx_filt) begin
      demod_next = ubir_pkg::BIT_SAMPLES;
    end else if (tick_next && demod_reg != '0) begin
      demod_next = demod_reg - 1'b1;
    end
    if (!receiver_enable) begin
      rx_next = 1'b1;
    end else if (coded) begin
      rx_next = demod_next == '0;
    end else begin
      rx_next = rx_src; // [RULE_11] [RULE_16]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      demod_reg <= '0;
      prev_reg <= 1'b1;
      rx_reg <= 1'b1;
    end else begin
      demod_reg <= demod_next;
      prev_reg <= prev_next;
      rx_reg <= rx_next;
    end
  end

  assign rd_data = rd_reg;
  assign txd_out = txd_reg;
  assign rx_serial = rx_reg;
  assign sample_tick = tick_reg;
  assign baud_divisor = div_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_start;
    pulse_start;
  endsequence

  a_div_low_byte: assert property ( // [RULE_01]
    wr_en && addr == ubir_pkg::OFS_DIV_LOW |=> baud_divisor[7:0] == $past(wr_data))
    else $error("Divisor low byte not written");
  a_div_high_byte: assert property ( // [RULE_01]
    wr_en && addr == ubir_pkg::OFS_DIV_HIGH ##1 rd_en && addr == ubir_pkg::OFS_DIV_HIGH
    |=> rd_data == $past(wr_data, 2))
    else $error("Divisor high byte not read back");
  a_presc_reload: assert property (div_wr |=> presc_reg == baud_divisor) // [RULE_02]
    else $error("Prescaler not reloaded on divisor write");
  a_halt_freeze: assert property ( // [RULE_04]
    halted && !div_wr |=> $stable(presc_reg) && !sample_tick)
    else $error("Prescaler ran while halted");
  a_debug_run: assert property ( // [RULE_05]
    debug_halted && dbg_reg[0] && !div_wr && presc_reg != '0
    |=> presc_reg == $past(presc_reg) - 16'h0001)
    else $error("Prescaler stopped with run bit set");
  a_event_source: assert property ( // [RULE_07]
    ir_mode && bypass && ev_reg[0] && !halted && receiver_enable |=> rx_serial == $past(event_in))
    else $error("Event input not routed to receiver");
  a_frac_pulse: assert property ( // [RULE_08]
    s_start and tx_pulse_width_value_reg == 8'h00 |=> pulse_reg == 8'h03 && frac_reg)
    else $error("Sixteenths pulse not three samples");
  a_fixed_pulse: assert property ( // [RULE_09]
    s_start and tx_pulse_width_value_reg != 8'h00 |=> pulse_reg == $past(tx_pulse_width_value_reg) && !txd_out)
    else $error("Fixed pulse length wrong");
  a_pulse_align: assert property ($fell(txd_out) && $past(coded) |-> $past(baud_rise)) // [RULE_10]
    else $error("Pulse not aligned to baud edge");
  a_non_ir_tx: assert property (!ir_mode |=> txd_out == $past(tx_serial)) // [RULE_12]
    else $error("Transmit line altered outside infrared mode");
  a_non_ir_rx: assert property ( // [RULE_16]
    !ir_mode && receiver_enable |=> rx_serial == $past(rxd_sync))
    else $error("Receive path altered outside infrared mode");
  // Idle cycles must never leave stale data on the read port
  a_rd_idle: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("Read data not cleared after read cycle");
  a_bypass_tx: assert property ( // [RULE_11]
    ir_mode && bypass |=> txd_out == $past(tx_serial))
    else $error("Bypass width altered transmit line");
  a_event_halted: assert property ( // [RULE_04]
    ir_mode && bypass && ev_reg[0] && halted && receiver_enable |=> rx_serial)
    else $error("Event seen while halted");
  a_rx_disabled: assert property (!receiver_enable |=> rx_serial)
    else $error("Receiver input not idle while disabled");
  // A fixed pulse must finish: its width steps down once per running cycle
  a_fixed_count: assert property ( // [RULE_09]
    coded && !halted && !frac_reg && pulse_reg > 8'h01 |=> pulse_reg == $past(pulse_reg) - 8'h01)
    else $error("Fixed pulse counter did not step");
  a_tick_single: assert property (
    sample_tick && baud_divisor != 16'h0000 |=> !sample_tick)
    else $error("Sample tick longer than one cycle");
endmodule
`default_nettype wire

// *** ubir_far_model.sv ***
// Far-side infrared transceiver model on the pins of the block.
// Assumes the block's clk_sys; the receive pin idles high as with a pull-up.
`default_nettype none
module ubir_far_model (
  input wire logic clk_sys,
  input wire logic txd_out,
  output logic rxd_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] run = 9'h000;
  logic [8:0] last_low = 9'h000;
  initial rxd_pin = 1'b1;
  // Width of the latest light pulse, in clk_sys cycles
  always @(posedge clk_sys) begin
    if (txd_out === 1'b0) begin
      run <= run + 9'h001;
    end else begin
      if (run != 9'h000) begin
        last_low <= run;
      end
      run <= 9'h000;
    end
  end
  task automatic pulse(input int n);
    @(posedge clk_sys);
    rxd_pin <= 1'b0;
    repeat (n) @(posedge clk_sys);
    rxd_pin <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the divisor, debug control and infrared coder.
// Assumes ubir_top alone on one clock, far-side model on its pins.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic [1:0] cm = 2'h0;
  logic te = 1'b0;
  logic re = 1'b0;
  logic dh = 1'b0;
  logic ev = 1'b1;
  logic rxd, txd, rxs, tick;
  logic txs = 1'b1;
  logic [15:0] div;
  int rx_lows = 0;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int k;
  always #10 clk_sys = ~clk_sys;
  ubir_top i_dut (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wr_data(wd),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .comm_mode(cm),
    .transmitter_enable(te), .receiver_enable(re), .debug_halted(dh),
    .event_in(ev), .rxd_pin(rxd), .tx_serial(txs), .txd_out(txd),
    .rx_serial(rxs), .sample_tick(tick), .baud_divisor(div));
  ubir_far_model i_far (.clk_sys(clk_sys), .txd_out(txd), .rxd_pin(rxd));
  always @(posedge clk_sys) begin
    if (rxs === 1'b0) begin
      rx_lows <= rx_lows + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      $display("unexpected run length: expected end, seen %0d cycles", cyc);
      wrap_up();
    end
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wd <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk("rd_data", {8'h00, e}, {8'h00, rd_data});
  endtask
  // Cycles between two sample ticks, or tick count over n cycles
  task automatic period(input int n, input logic cnt);
    int c;
    c = 0;
    k = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      c++;
      if (tick === 1'b1) begin
        k = cnt ? k + 1 : c;
        c = 0;
      end
    end
  endtask
  task automatic t_regs();
    rc(8'h08, 8'h00);
    rc(8'h09, 8'h00);
    rc(8'h0b, 8'h00);
    rc(8'h0c, 8'h00);
    rc(8'h0d, 8'h00);
    rc(8'h0e, 8'h00);
    wr(8'h08, 8'ha5);
    wr(8'h09, 8'h3c);
    @(posedge clk_sys);
    chk("baud_divisor", 16'h3ca5, div);
    rc(8'h09, 8'h3c);
    wr(8'h0b, 8'hff);
    wr(8'h0e, 8'hff);
    wr(8'h0a, 8'h5a);
    rc(8'h0b, 8'h01);
    rc(8'h0e, 8'h7f);
    rc(8'h0a, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_baud();
    // Divisor changes only while nothing is in flight
    wr(8'h09, 8'h00);
    wr(8'h08, 8'h03);
    period(13, 1'b0);
    chk("tick period", 16'h0004, 16'(k));
    wr(8'h08, 8'h07);
    period(25, 1'b0);
    chk("tick period", 16'h0008, 16'(k));
    wr(8'h0b, 8'h00);
    wr(8'h08, 8'h03);
    dh <= 1'b1;
    period(2, 1'b1);
    period(20, 1'b1);
    chk("halted ticks", 16'h0000, 16'(k));
    wr(8'h0b, 8'h01);
    period(20, 1'b1);
    chk("run ticks", 16'h0005, 16'(k));
    dh <= 1'b0;
    wr(8'h08, 8'h01);
    $display("test baud and debug done");
  endtask
  // Width is written before the transmitter is enabled
  task automatic tx(input logic [1:0] m, input logic [7:0] w, input logic [8:0] e);
    @(posedge clk_sys);
    te <= 1'b0;
    cm <= m;
    wr(8'h0d, w);
    te <= 1'b1;
    txs <= 1'b0;
    repeat (40) @(posedge clk_sys);
    txs <= 1'b1;
    repeat (300) @(posedge clk_sys);
    chk("txd_out low width", {7'h00, e}, {7'h00, i_far.last_low});
  endtask
  // Length is written before the receiver is enabled
  task automatic rx(input logic [1:0] m, input logic [7:0] c, input logic [7:0] w,
      input logic [7:0] l, input logic src, input int n, input logic e);
    int base;
    @(posedge clk_sys);
    re <= 1'b0;
    cm <= m;
    wr(8'h0c, c);
    wr(8'h0d, w);
    wr(8'h0e, l);
    re <= 1'b1;
    repeat (40) @(posedge clk_sys);
    base = rx_lows;
    if (src) begin
      ev <= 1'b0;
      repeat (n) @(posedge clk_sys);
      ev <= 1'b1;
    end else begin
      i_far.pulse(n);
    end
    repeat (60) @(posedge clk_sys);
    chk("rx_serial went low", {15'h0000, e}, {15'h0000, rx_lows != base});
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_baud();
    // Divisor 1: ticks every 2 cycles, speed mode kept normal
    tx(2'h2, 8'h00, 9'h006);
    tx(2'h2, 8'h01, 9'h001);
    tx(2'h2, 8'h05, 9'h005);
    tx(2'h2, 8'hfe, 9'h0fe);
    tx(2'h2, 8'hff, 9'h028);
    tx(2'h0, 8'h05, 9'h028);
    $display("test transmit done");
    rx(2'h2, 8'h01, 8'hff, 8'h00, 1'b1, 5, 1'b1);
    rx(2'h2, 8'h01, 8'hff, 8'h00, 1'b0, 5, 1'b0);
    rx(2'h2, 8'h00, 8'h00, 8'h03, 1'b0, 3, 1'b0);
    rx(2'h2, 8'h00, 8'h00, 8'h03, 1'b0, 4, 1'b1);
    rx(2'h2, 8'h00, 8'h00, 8'h00, 1'b0, 2, 1'b1);
    rx(2'h0, 8'h00, 8'h00, 8'h03, 1'b0, 2, 1'b1);
    $display("test receive done");
    wrap_up();
  end
endmodule
`default_nettype wire
